/* verilog/wdt_pkg.sv */
// Purpose: Shared constants for the watchdog downcounter block.
// Assumes: 10 MHz core clock stands in for the oscillator clock.
// Notes: One 8-bit control register held in a 32-bit bus word.
package wdt_pkg;
  localparam int WDT_OSC_PER_TICK = 3072;
  localparam int WDT_RST_PULSE_NS = 500;
  localparam int WDT_CLK_PERIOD_NS = 100;
  localparam int WDT_RST_PULSE_CYC =
    (WDT_RST_PULSE_NS + WDT_CLK_PERIOD_NS - 1) / WDT_CLK_PERIOD_NS;
  localparam logic [11:0] WDT_TICK_LAST = 12'(WDT_OSC_PER_TICK - 1);
  localparam logic [3:0] WDT_PULSE_LAST = 4'(WDT_RST_PULSE_CYC - 1);
  localparam logic [11:0] WDT_REG_ADDR = 12'h0d8;
  localparam logic [11:0] WDT_STAT_ADDR = 12'h0dc;
  localparam logic [7:0] WDT_REG_RESET = 8'hfe;
  localparam int WDT_BIT_ENABLE = 0;
  localparam int WDT_BIT_SOFTRST = 1;
  localparam logic [1:0] WDT_RESP_OKAY = 2'b00;
  localparam logic [1:0] WDT_RESP_SLVERR = 2'b10;
  typedef logic [7:0] wdt_byte_t;
endpackage : wdt_pkg

/* verilog/wdt_cnt_if.sv */
// Purpose: Carries counter controls between the top and the counter core.
// Assumes: One clock domain.
// Notes: Load has priority over tick.
`timescale 1ns/1ps
interface wdt_cnt_if;
  logic load;
  logic [6:0] load_val;
  logic tick;
  logic freeze;
  logic [6:0] count;
  modport ctl (output load, output load_val, output tick, output freeze,
               input count);
  modport core (input load, input load_val, input tick, input freeze,
                output count);
endinterface : wdt_cnt_if

/* verilog/wdt_counter.sv */
// Purpose: 7-bit downcounter (soft reset flag as MSB, count bits below).
// Assumes: Software writes keep the flag set except to force a reset.
// Notes: Wraps from zero when used as a plain timer.
`timescale 1ns/1ps
module wdt_counter (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Controls
  wdt_cnt_if.core cnt
);
  import wdt_pkg::*;

  logic [6:0] count_ff;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_ff <= 7'h7f;
    end else if (cnt.load) begin
      count_ff <= cnt.load_val;
    end else if (cnt.tick && !cnt.freeze) begin
      count_ff <= count_ff - 7'h01;
    end
  end

  assign cnt.count = count_ff;
endmodule : wdt_counter

/* verilog/wdt_top.sv */
// Purpose: Watchdog downcounter with soft reset, AXI4-Lite register access.
// Assumes: Option straps are static; stop request and nmi are synchronous.
// Notes: Register byte at 0x0d8, status at 0x0dc; reset pulse is 5 cycles.
//
// How it works
// - Hardware option: always active, enable bit not forced
// - Hardware option: enable bit reads unreliable
// - Software option: enable set once, sticks
// - Counter decrements every 3072 clocks
// - Timeout chosen in 64 count steps
// - Flag at zero while active: reset pulse
// - Clearing flag while enabled forces reset
// - Run needs enable, flag set, count loaded
// - FEh gives 24.576 ms, 02h 0.384 ms
// - Inactive: plain reversed 7-bit timer, no reset
// - Bits 7..2 reversed count, flag, enable
// - Register at 0D8h, read/write, resets FEh
// - Inactive: flag is timer MSB
// - Active stop acts as wait unless stop-control
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module wdt_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Option straps and low-power inputs
  input wire logic hardware_activation_option,
  input wire logic external_stop_option,
  input wire logic stop_req,
  input wire logic nmi_in,
  // Reset and mode outputs
  output logic chip_rst_b,
  output logic wdt_active,
  output logic stop_granted,
  // AXI4-Lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import wdt_pkg::*;

  // --------------------------------------------------------------
  // Bus slave state
  // --------------------------------------------------------------
  logic aw_held_ff;
  logic w_held_ff;
  logic [11:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic wr_fire;
  logic wr_hit;
  logic [7:0] wr_byte;

  // --------------------------------------------------------------
  // Watchdog state
  // --------------------------------------------------------------
  logic sw_enable_ff;
  logic [11:0] presc_ff;
  logic [3:0] pulse_cnt_ff;
  logic pulse_on_ff;
  logic sw_rst_seen_ff;
  logic enable_bit;
  logic frozen;
  logic tick;
  logic expire;
  logic sw_kill;
  wdt_byte_t reg_view;

  wdt_cnt_if cnt_if ();

  // --------------------------------------------------------------
  // Write channel: address and data taken in either order
  // --------------------------------------------------------------
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_hit = wr_fire && (awaddr_ff == WDT_REG_ADDR) && wstrb_ff[0];
  assign wr_byte = wdata_ff[7:0];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= {s_axi_awaddr[11:2], 2'b00};
    end else if (wr_fire) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_ff <= 1'b0;
    end
  end

  // Unmapped writes are answered SLVERR; status word is read-only
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= WDT_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (awaddr_ff == WDT_REG_ADDR) ? WDT_RESP_OKAY
                                               : WDT_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // --------------------------------------------------------------
  // Read channel
  // --------------------------------------------------------------
  assign s_axi_arready = !rvalid_ff;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= WDT_RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      if ({s_axi_araddr[11:2], 2'b00} == WDT_REG_ADDR) begin
        rresp_ff <= WDT_RESP_OKAY;
        rdata_ff <= {24'h00_0000, reg_view};
      end else if ({s_axi_araddr[11:2], 2'b00} == WDT_STAT_ADDR) begin
        rresp_ff <= WDT_RESP_OKAY;
        rdata_ff <= {29'h0000_0000, stop_granted, pulse_on_ff,
                     wdt_active};
      end else begin
        rresp_ff <= WDT_RESP_SLVERR;
        rdata_ff <= 32'h0000_0000;
      end
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

  // --------------------------------------------------------------
  // Activation
  // --------------------------------------------------------------
  // Enable only ever sets; only a device reset clears it
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sw_enable_ff <= 1'b0;
    end else if (wr_hit && wr_byte[WDT_BIT_ENABLE]) begin
      sw_enable_ff <= 1'b1;
    end
  end

  // Forced active by the strap; written enable is then ignored
  assign wdt_active = hardware_activation_option || sw_enable_ff;
  // Under the strap the bit reads as the stored software copy, which
  // software must not rely on
  assign enable_bit = sw_enable_ff;

  // --------------------------------------------------------------
  // Prescaler and counter
  // --------------------------------------------------------------
  // Stop freezes the count only with stop-control chosen and nmi high
  assign stop_granted = stop_req && (!wdt_active ||
                        (external_stop_option && nmi_in));
  assign frozen = wdt_active && stop_granted;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      presc_ff <= 12'h000;
    end else if (wr_hit) begin
      presc_ff <= 12'h000;
    end else if (!frozen) begin
      presc_ff <= (presc_ff == WDT_TICK_LAST) ? 12'h000
                                              : presc_ff + 12'h001;
    end
  end

  assign tick = (presc_ff == WDT_TICK_LAST);

  // Count byte is bit-reversed: bit 7 is counter LSB, bit 2 its bit 5, flag its MSB
  assign cnt_if.load = wr_hit;
  assign cnt_if.load_val = {wr_byte[WDT_BIT_SOFTRST], wr_byte[2],
                            wr_byte[3], wr_byte[4], wr_byte[5],
                            wr_byte[6], wr_byte[7]};
  assign cnt_if.tick = tick;
  assign cnt_if.freeze = frozen;

  wdt_counter u_counter (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .cnt(cnt_if)
  );

  // Flag is counter MSB, so it doubles as 7-bit timer top bit
  assign reg_view = {cnt_if.count[0], cnt_if.count[1], cnt_if.count[2],
                     cnt_if.count[3], cnt_if.count[4], cnt_if.count[5],
                     cnt_if.count[6], enable_bit};

  // --------------------------------------------------------------
  // Reset generation
  // --------------------------------------------------------------
  // Timer mode never resets: expiry needs the active state
  assign expire = wdt_active && !cnt_if.count[6];
  assign sw_kill = wr_hit && !wr_byte[WDT_BIT_SOFTRST] &&
                   (wdt_active || wr_byte[WDT_BIT_ENABLE]);

  // The pulse runs once per expiry; the system reset that follows
  // is expected to clear this block; the low level ends by itself after 5 cycles
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sw_rst_seen_ff <= 1'b0;
    end else begin
      sw_rst_seen_ff <= expire;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pulse_on_ff <= 1'b0;
      pulse_cnt_ff <= 4'h0;
    end else if (!pulse_on_ff && (sw_kill ||
                 (expire && !sw_rst_seen_ff))) begin
      pulse_on_ff <= 1'b1;
      pulse_cnt_ff <= 4'h0;
    end else if (pulse_on_ff) begin
      if (pulse_cnt_ff == WDT_PULSE_LAST) begin
        pulse_on_ff <= 1'b0;
      end
      pulse_cnt_ff <= pulse_cnt_ff + 4'h1;
    end
  end

  assign chip_rst_b = !pulse_on_ff;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  a_hw_forces_active: assert property (@(posedge core_clk)
    disable iff (!rst_b) hardware_activation_option |-> wdt_active)
    else $error("hardware option did not force active");

  a_enable_sticks: assert property (@(posedge core_clk)
    disable iff (!rst_b) sw_enable_ff |=> sw_enable_ff)
    else $error("enable bit cleared without reset");

  a_tick_spacing: assert property (@(posedge core_clk)
    disable iff (!rst_b) (tick && !wr_hit && !frozen) |=>
    !tick [*8])
    else $error("ticks too close together");

  a_count_steps: assert property (@(posedge core_clk)
    disable iff (!rst_b) (tick && !frozen && !wr_hit) |=>
    (cnt_if.count == $past(cnt_if.count) - 7'h01))
    else $error("counter did not step by one");

  a_write_loads: assert property (@(posedge core_clk)
    disable iff (!rst_b) wr_hit |=> (reg_view[7:1] == $past(wr_byte[7:1])))
    else $error("write did not load counter");

  a_expiry_pulse: assert property (@(posedge core_clk)
    disable iff (!rst_b) (expire && !sw_rst_seen_ff && !pulse_on_ff) |=>
    !chip_rst_b [*5] ##1 chip_rst_b)
    else $error("reset pulse wrong length");

  a_pulse_bounded: assert property (@(posedge core_clk)
    disable iff (!rst_b) pulse_on_ff |-> (pulse_cnt_ff <= WDT_PULSE_LAST))
    else $error("reset pulse counter overran");

  a_soft_reset: assert property (@(posedge core_clk)
    disable iff (!rst_b) (sw_kill && !pulse_on_ff) |=> !chip_rst_b)
    else $error("soft reset not issued");

  a_pulse_cause: assert property (@(posedge core_clk)
    disable iff (!rst_b) $rose(pulse_on_ff) |->
    ($past(sw_kill) || $past(expire)))
    else $error("reset pulse without a cause");

  a_timer_no_rst: assert property (@(posedge core_clk)
    disable iff (!rst_b) (!wdt_active && !pulse_on_ff && !sw_kill) |=>
    chip_rst_b)
    else $error("reset in timer mode");

  a_freeze_holds: assert property (@(posedge core_clk)
    disable iff (!rst_b) (frozen && !wr_hit) |=>
    $stable(cnt_if.count))
    else $error("counter moved while frozen");

  a_reset_value: assert property (@(posedge core_clk)
    $rose(rst_b) |-> (reg_view[7:1] == WDT_REG_RESET[7:1]))
    else $error("wrong reset value");

  c_soft_reset: cover property (@(posedge core_clk)
    disable iff (!rst_b) sw_kill);
  c_expiry: cover property (@(posedge core_clk)
    disable iff (!rst_b) expire && !sw_rst_seen_ff);
  c_frozen: cover property (@(posedge core_clk)
    disable iff (!rst_b) frozen);
  c_timer_wrap: cover property (@(posedge core_clk)
    disable iff (!rst_b) !wdt_active && tick && cnt_if.count == 7'h00);
  c_pulse_end: cover property (@(posedge core_clk)
    disable iff (!rst_b) $rose(chip_rst_b));
endmodule : wdt_top

/* sim/wdt_top_test.sv */
// Purpose: Self-checking bench for the watchdog downcounter block.
// Assumes: Straps change only while reset is held low.
// Notes: Drivers queue expected answers; monitors pop and compare them.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp=%h got=%h", nm, e, g); end end
module wdt_top_test;
  import wdt_pkg::*;
  typedef struct {logic [1:0] r; logic [31:0] d; bit c;} wdt_rexp_s;
  logic core_clk = 0, rst_b = 0, hardware_activation_option = 0;
  logic external_stop_option = 0, stop_req = 0, nmi_in = 0;
  logic chip_rst_b, wdt_active, stop_granted;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, eb;
  int fails = 0, n_tests = 0, lowcnt = 0, ep, k;
  logic [1:0] exp_b[$];
  wdt_rexp_s exp_r[$];
  wdt_rexp_s er;
  int exp_p[$];
  logic [7:0] v;

  always #50 core_clk = ~core_clk;

  wdt_top i_dut (.core_clk(core_clk), .rst_b(rst_b),
    .hardware_activation_option(hardware_activation_option),
    .external_stop_option(external_stop_option), .stop_req(stop_req),
    .nmi_in(nmi_in), .chip_rst_b(chip_rst_b), .wdt_active(wdt_active),
    .stop_granted(stop_granted), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  // ------------------------------------------------------------
  // Monitors
  // ------------------------------------------------------------
  always @(posedge core_clk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      eb = exp_b.pop_front();
      `CHK("bresp", eb, s_axi_bresp)
    end
    if (s_axi_rvalid && s_axi_rready) begin
      er = exp_r.pop_front();
      `CHK("rresp", er.r, s_axi_rresp)
      if (er.c)
        `CHK("rdata", er.d, s_axi_rdata)
    end
    // Width of each reset pulse is measured in whole clock cycles
    if (!chip_rst_b) begin
      lowcnt++;
    end else if (lowcnt != 0) begin
      ep = exp_p.pop_front();
      `CHK("pulse_cycles", ep, lowcnt)
      lowcnt = 0;
    end
  end

  // ------------------------------------------------------------
  // Bus and control tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] r);
    exp_b.push_back(r);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) ||
               (s_axi_wvalid && !s_axi_wready));
    while (!s_axi_bvalid) @(posedge core_clk);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [1:0] r,
                    input logic [31:0] d, input bit c);
    exp_r.push_back('{r: r, d: d, c: c});
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic do_rst(input logic h, input logic e);
    @(posedge core_clk);
    rst_b <= 1'b0;
    hardware_activation_option <= h;
    external_stop_option <= e;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
  endtask : do_rst

  // Counts edges until the reset output is seen low, giving up at lim
  task automatic wait_low(input int lim);
    for (k = 0; k < lim && chip_rst_b !== 1'b0; k++) @(posedge core_clk);
  endtask : wait_low

  task automatic summarize;
    $display("tests=%0d fails=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'hc6d5bd4f));
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(WDT_REG_ADDR, WDT_RESP_OKAY, 32'h000000fe, 1);
    rd(12'h100, WDT_RESP_SLVERR, 32'h0, 0);
    wr(12'h100, 8'h00, WDT_RESP_SLVERR);
    wr(WDT_STAT_ADDR, 8'h01, WDT_RESP_SLVERR);
    `CHK("active_sw", 1'b0, wdt_active)
    stop_req <= 1'b1;
    @(posedge core_clk);
    `CHK("stop_idle", 1'b1, stop_granted)
    // Random timer loads keep the flag set and the enable clear
    repeat (4) begin
      v = {6'($urandom()), 2'b10};
      wr(WDT_REG_ADDR, v, WDT_RESP_OKAY);
      rd(WDT_REG_ADDR, WDT_RESP_OKAY, {24'h000000, v}, 1);
    end
    // Flag alone set: one decrement turns it into all count bits
    wr(WDT_REG_ADDR, 8'h02, WDT_RESP_OKAY);
    repeat (3060) @(posedge core_clk);
    rd(WDT_REG_ADDR, WDT_RESP_OKAY, 32'h00000002, 1);
    repeat (20) @(posedge core_clk);
    rd(WDT_REG_ADDR, WDT_RESP_OKAY, 32'h000000fc, 1);
    `CHK("timer_no_rst", 1'b1, chip_rst_b)
    wr(WDT_REG_ADDR, 8'hff, WDT_RESP_OKAY);
    `CHK("active_set", 1'b1, wdt_active)
    `CHK("stop_as_wait", 1'b0, stop_granted)
    rd(WDT_STAT_ADDR, WDT_RESP_OKAY, 32'h00000001, 1);
    wr(WDT_REG_ADDR, 8'hfe, WDT_RESP_OKAY);
    `CHK("active_sticky", 1'b1, wdt_active)
    // Refreshing before the flag drops keeps the device out of reset
    repeat (2) begin
      wr(WDT_REG_ADDR, 8'h83, WDT_RESP_OKAY);
      repeat (6000) @(posedge core_clk);
      `CHK("refreshed", 1'b1, chip_rst_b)
    end
    // Count of one plus flag: expiry after exactly two decrements
    exp_p.push_back(WDT_RST_PULSE_CYC);
    wr(WDT_REG_ADDR, 8'h83, WDT_RESP_OKAY);
    repeat (6135) @(posedge core_clk);
    `CHK("early_rst", 1'b1, chip_rst_b)
    wait_low(20);
    `CHK("expiry_seen", 1'b1, k < 20)
    repeat (10) @(posedge core_clk);
    do_rst(1'b0, 1'b0);
    `CHK("active_cleared", 1'b0, wdt_active)
    wr(WDT_REG_ADDR, 8'hff, WDT_RESP_OKAY);
    // Timer user finds the enable set and forces the reset itself
    rd(WDT_REG_ADDR, WDT_RESP_OKAY, 32'h000000ff, 1);
    exp_p.push_back(WDT_RST_PULSE_CYC);
    wr(WDT_REG_ADDR, 8'hfd, WDT_RESP_OKAY);
    wait_low(4);
    `CHK("soft_rst", 1'b1, k < 4)
    repeat (10) @(posedge core_clk);
    do_rst(1'b1, 1'b1);
    `CHK("active_hw", 1'b1, wdt_active)
    nmi_in <= 1'b1;
    @(posedge core_clk);
    `CHK("stop_nmi_hi", 1'b1, stop_granted)
    // Stop granted while active: the count must not move past a tick
    wr(WDT_REG_ADDR, 8'h83, WDT_RESP_OKAY);
    repeat (3100) @(posedge core_clk);
    rd(WDT_REG_ADDR, WDT_RESP_OKAY, 32'h00000083, 1);
    nmi_in <= 1'b0;
    @(posedge core_clk);
    `CHK("stop_nmi_lo", 1'b0, stop_granted)
    // Enable written zero: the strap still arms the soft reset
    exp_p.push_back(WDT_RST_PULSE_CYC);
    wr(WDT_REG_ADDR, 8'h04, WDT_RESP_OKAY);
    wait_low(4);
    `CHK("hw_soft_rst", 1'b1, k < 4)
    repeat (10) @(posedge core_clk);
    summarize();
  end

  initial begin
    #(40000 * 100);
    fails++;
    $display("BAD watchdog exp=done got=hang");
    summarize();
  end
endmodule : wdt_top_test
